// file: src/fcma_pkg.sv
// Constants, register map and carrier types of the five-channel monitor.
// Assumes a 40 MHz system clock and 32-bit Avalon-MM register access.
package fcma_pkg;

    // ************************************************
    // Channels and code format
    // ************************************************
    localparam int         NCH       = 5;
    localparam int         CODE_W    = 16;
    localparam int         SIG_W     = 12;
    localparam logic [2:0] CH_TEMP   = 3'h0;
    localparam logic [2:0] CH_SUPPLY = 3'h1;
    localparam logic [2:0] CH_IN_A   = 3'h2;
    localparam logic [2:0] CH_IN_B   = 3'h3;
    localparam logic [2:0] CH_IN_C   = 3'h4;
    localparam logic [2:0] CH_LAST   = CH_IN_C;

    // Full-scale codes: temperature signed, others unsigned
    localparam logic [15:0] TEMP_POS_FS = 16'h7fff;
    localparam logic [15:0] TEMP_NEG_FS = 16'h8000;
    localparam logic [15:0] UNS_FS      = 16'hffff;
    localparam logic [15:0] UNS_ZERO    = 16'h0000;

    // Code weights in nano- and picovolts, for software scaling
    localparam int SUPPLY_LSB_NV = 100000;
    localparam int INPUT_LSB_PV  = 38147000;

    // ************************************************
    // Timing
    // ************************************************
    localparam int CLK_MHZ       = 40;
    localparam int FRAME_TYP_US  = 25000;
    localparam int FRAME_MAX_US  = 36000;
    localparam int FRAME_TYP_CYC = FRAME_TYP_US * CLK_MHZ;
    localparam int FRAME_MAX_CYC = FRAME_MAX_US * CLK_MHZ;
    localparam int SLOT_CYC_DEF  = FRAME_TYP_CYC / NCH;

    // ************************************************
    // Register map (byte addresses)
    // ************************************************
    localparam logic [7:0] OFS_RESULT    = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h14;
    localparam logic [7:0] OFS_MASK      = 8'h18;
    localparam logic [7:0] OFS_CTRL      = 8'h1c;
    localparam logic [7:0] OFS_LIMIT     = 8'h20;
    localparam logic [7:0] OFS_LIMIT_END = 8'h48;
    localparam int         CTRL_ALARM_OUT = 0;
    localparam int         CTRL_MAIN_PROT = 1;
    localparam logic [1:0] CTRL_RST       = 2'h0;

    // Synchronised pin vector
    localparam int         PIN_BUF_A = 0;
    localparam int         PIN_BUF_B = 1;
    localparam int         PIN_WP    = 2;
    localparam int         PIN_OD_A  = 3;
    localparam int         PIN_OD_B  = 4;
    localparam int         NPIN      = 5;
    localparam logic [4:0] PIN_IDLE  = 5'h1f;

    // ************************************************
    // Carrier types
    // ************************************************
    typedef struct packed {
        logic [NCH-1:0] lo;
        logic [NCH-1:0] hi;
        logic [NCH-1:0] done;
    } fcma_flags_t;

    typedef struct packed {
        logic              valid;
        logic [CODE_W-1:0] code;
    } fcma_sample_t;

endpackage

// file: src/fcma_rx.sv
// Serial result receiver: one 16-bit word, MSB first, per start.
// Assumes converter clock and data arrive from outside the CLK domain.
`timescale 1ns/1ps
module fcma_rx import fcma_pkg::*; (
    input  logic         CLK,
    input  logic         RESET,
    input  logic         CE,
    input  logic         start,
    input  logic         sclk_pin,
    input  logic         sdata_pin,
    output fcma_sample_t smp
);
    logic [1:0]        s1_q;
    logic [1:0]        s2_q;
    logic              sclk_d_q;
    logic [3:0]        cnt_q;
    logic [CODE_W-1:0] sh_q;
    fcma_sample_t      smp_q;
    logic              rise;
    logic [CODE_W-1:0] sh_d;

    // ************************************************
    // Synchroniser, clock edge finder
    // ************************************************
    always_ff @(posedge CLK) begin
        if (RESET) begin
            s1_q     <= 2'h0;
            s2_q     <= 2'h0;
            sclk_d_q <= 1'b0;
        end else if (CE) begin
            s1_q     <= {sdata_pin, sclk_pin};
            s2_q     <= s1_q;
            sclk_d_q <= s2_q[0];
        end
    end

    assign rise = s2_q[0] & ~sclk_d_q;
    assign sh_d = {sh_q[CODE_W-2:0], s2_q[1]};

    // Shift on rising edges; a start drops any partial word
    always_ff @(posedge CLK) begin
        if (RESET) begin
            cnt_q <= 4'h0;
            sh_q  <= '0;
            smp_q <= '0;
        end else if (CE) begin
            smp_q.valid <= 1'b0;
            if (start) begin
                cnt_q <= 4'h0;
            end else if (rise) begin
                sh_q  <= sh_d;
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == 4'hf) begin
                    smp_q <= {1'b1, sh_d};
                end
            end
        end
    end

    assign smp = smp_q;
endmodule

// file: src/fcma_top.sv
// Five-channel monitor: round-robin sampling, limits, alarms, buffers.
// Assumes an Avalon-MM master on CLK and a serial converter whose
// clock and data are asynchronous pins sampled by CLK.
`timescale 1ns/1ps

module fcma_top import fcma_pkg::*; #(
    parameter int SLOT_CYCLES = SLOT_CYC_DEF
) (
    input  logic        CLK,
    input  logic        RESET,
    input  logic        CE,
    input  logic [7:0]  AVS_ADDRESS,
    input  logic        AVS_READ,
    input  logic        AVS_WRITE,
    input  logic [31:0] AVS_WRITEDATA,
    input  logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic        AVS_WAITREQUEST,
    output logic        IRQ,
    output logic        CONV_START,
    output logic [2:0]  CONV_CHANNEL,
    input  logic        ADC_SCLK,
    input  logic        ADC_SDATA,
    input  logic        BUFFER_IN_A,
    input  logic        BUFFER_IN_B,
    input  logic        WRITE_PROTECT_PIN,
    input  logic        OPEN_DRAIN_OUT_A_I,
    output logic        OPEN_DRAIN_OUT_A_O,
    output logic        OPEN_DRAIN_OUT_A_OE_N,
    input  logic        OPEN_DRAIN_OUT_B_I,
    output logic        OPEN_DRAIN_OUT_B_O,
    output logic        OPEN_DRAIN_OUT_B_OE_N
);
    localparam int            SW        = $clog2(SLOT_CYCLES);
    localparam logic [SW-1:0] SLOT_LAST = SW'(SLOT_CYCLES - 1);

    // Too short a slot cannot hold a word; too long breaks the frame
    if (SLOT_CYCLES < 64 || SLOT_CYCLES * NCH > FRAME_MAX_CYC) begin : g_chk
        $error("SLOT_CYCLES out of range");
    end

    logic [NPIN-1:0]   pin_s1_q;
    logic [NPIN-1:0]   pin_s2_q;
    logic [SW-1:0]     slot_q;
    logic [2:0]        ch_q;
    logic              start_q;
    logic              slot_end;
    logic [NCH-1:0]    ch_oh;
    fcma_sample_t      smp;
    logic [CODE_W-1:0] code_lj;
    logic [CODE_W-1:0] res_q [NCH];
    logic [NCH-1:0]    hi_hit;
    logic [NCH-1:0]    lo_hit;
    fcma_flags_t       flags_q;
    fcma_flags_t       set_v;
    logic [3*NCH-1:0]  clr_v;
    logic [3*NCH-1:0]  mask_q;
    logic [1:0]        ctrl_q;
    logic              wait_q;
    logic [31:0]       rdata_q;
    logic [31:0]       rd_d;
    logic              wr_ok;
    logic              wp_block;
    logic [15:0]       be16;
    logic [15:0]       wd16;
    logic [7:0]        loff;
    logic              in_res;
    logic              in_lim;
    logic [CODE_W-1:0] hi_q [NCH];
    logic [CODE_W-1:0] lo_q [NCH];
    logic              irq_q;
    logic              oda_oe_n_q;
    logic              odb_oe_n_q;
    logic              od_low_q;

    // ************************************************
    // Pin synchronisers
    // ************************************************
    // Idle high: the protect pin floats high when left open
    always_ff @(posedge CLK) begin
        if (RESET) begin
            pin_s1_q <= PIN_IDLE;
            pin_s2_q <= PIN_IDLE;
        end else if (CE) begin
            pin_s1_q <= {OPEN_DRAIN_OUT_B_I, OPEN_DRAIN_OUT_A_I,
                         WRITE_PROTECT_PIN, BUFFER_IN_B, BUFFER_IN_A};
            pin_s2_q <= pin_s1_q;
        end
    end

    // ************************************************
    // Conversion sequencer
    // ************************************************
    assign slot_end = (slot_q == SLOT_LAST);
    assign ch_oh    = {{(NCH-1){1'b0}}, 1'b1} << ch_q;

    // Fixed slot per channel, so each frame is exactly NCH slots
    always_ff @(posedge CLK) begin
        if (RESET) begin
            slot_q  <= '0;
            ch_q    <= CH_TEMP;
            start_q <= 1'b0;
        end else if (CE) begin
            start_q <= (slot_q == '0);
            if (slot_end) begin
                slot_q <= '0;
                ch_q   <= (ch_q == CH_LAST) ? CH_TEMP : ch_q + 3'h1;
            end else begin
                slot_q <= slot_q + SW'(1);
            end
        end
    end

    fcma_rx u_rx (
        .CLK       (CLK),
        .RESET     (RESET),
        .CE        (CE),
        .start     (start_q),
        .sclk_pin  (ADC_SCLK),
        .sdata_pin (ADC_SDATA),
        .smp       (smp)
    );

    // Low four bits carry no data, so they are forced to zero
    assign code_lj = {smp.code[CODE_W-1:CODE_W-SIG_W], 4'h0};

    // ************************************************
    // Result store
    // ************************************************
    // A word arriving late lands in the slot of the channel current then
    always_ff @(posedge CLK) begin
        if (RESET) begin
            for (int i = 0; i < NCH; i++) begin
                res_q[i] <= '0;
            end
        end else if (CE && smp.valid) begin
            res_q[ch_q] <= code_lj;
        end
    end

    // ************************************************
    // Bus decode
    // ************************************************
    assign wr_ok    = AVS_WRITE && !wait_q && CE;
    assign wp_block = pin_s2_q[PIN_WP] && ctrl_q[CTRL_MAIN_PROT];
    assign be16     = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
    assign wd16     = AVS_WRITEDATA[15:0];
    assign loff     = AVS_ADDRESS - OFS_LIMIT;
    assign in_res   = AVS_ADDRESS < OFS_STATUS;
    assign in_lim   = AVS_ADDRESS >= OFS_LIMIT && AVS_ADDRESS < OFS_LIMIT_END;

    // ************************************************
    // Limits and comparators, per channel
    // ************************************************
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        localparam logic        SIGNED = (g == int'(CH_TEMP));
        localparam logic [15:0] HI_RST = SIGNED ? TEMP_POS_FS : UNS_FS;
        localparam logic [15:0] LO_RST = SIGNED ? TEMP_NEG_FS : UNS_ZERO;
        logic hit;

        assign hit = in_lim && loff[5:3] == 3'(g) && wr_ok && !wp_block;

        // Limits can be written only while protection is off
        always_ff @(posedge CLK) begin
            if (RESET) begin
                hi_q[g] <= HI_RST;
                lo_q[g] <= LO_RST;
            end else if (hit && !loff[2]) begin
                hi_q[g] <= (hi_q[g] & ~be16) | (wd16 & be16);
            end else if (hit && loff[2]) begin
                lo_q[g] <= (lo_q[g] & ~be16) | (wd16 & be16);
            end
        end

        // Same format as the stored code
        assign hi_hit[g] = SIGNED ? $signed(code_lj) > $signed(hi_q[g])
                                  : code_lj > hi_q[g];
        assign lo_hit[g] = SIGNED ? $signed(code_lj) < $signed(lo_q[g])
                                  : code_lj < lo_q[g];

        AST_PROTECT: assert property (@(posedge CLK) disable iff (RESET)
            (wr_ok && wp_block && in_lim && loff[5:3] == 3'(g))
            |=> $stable(hi_q[g]) && $stable(lo_q[g]))
            else $error("protected limit changed");
    end

    // ************************************************
    // Sticky flags, mask, control
    // ************************************************
    assign set_v.done = smp.valid ? ch_oh : '0;
    assign set_v.hi   = smp.valid ? (ch_oh & hi_hit) : '0;
    assign set_v.lo   = smp.valid ? (ch_oh & lo_hit) : '0;
    assign clr_v      = (wr_ok && AVS_ADDRESS == OFS_STATUS)
                      ? (AVS_WRITEDATA[3*NCH-1:0] & be16[3*NCH-1:0]) : '0;

    // A set in the clearing cycle wins over the clear
    always_ff @(posedge CLK) begin
        if (RESET) begin
            flags_q <= '0;
        end else if (CE) begin
            flags_q <= fcma_flags_t'((flags_q & ~clr_v) | set_v);
        end
    end

    // Flags stay clearable while protected, like scratch memory
    always_ff @(posedge CLK) begin
        if (RESET) begin
            mask_q <= '0;
            ctrl_q <= CTRL_RST;
        end else if (wr_ok && !wp_block) begin
            if (AVS_ADDRESS == OFS_MASK) begin
                mask_q <= (mask_q & ~be16[3*NCH-1:0])
                        | (AVS_WRITEDATA[3*NCH-1:0] & be16[3*NCH-1:0]);
            end
            if (AVS_ADDRESS == OFS_CTRL && AVS_BYTEENABLE[0]) begin
                ctrl_q <= AVS_WRITEDATA[1:0];
            end
        end
    end

    // ************************************************
    // Read mux and wait state
    // ************************************************
    always_comb begin
        rd_d = '0;
        if (in_res) begin
            rd_d = {16'h0, res_q[AVS_ADDRESS[4:2]]};
        end else if (in_lim) begin
            rd_d = {16'h0, loff[2] ? lo_q[loff[5:3]] : hi_q[loff[5:3]]};
        end else if (AVS_ADDRESS == OFS_STATUS) begin
            rd_d = {17'h0, flags_q};
        end else if (AVS_ADDRESS == OFS_MASK) begin
            rd_d = {17'h0, mask_q};
        end else if (AVS_ADDRESS == OFS_CTRL) begin
            rd_d = {27'h0, pin_s2_q[PIN_WP], pin_s2_q[PIN_OD_B],
                    pin_s2_q[PIN_OD_A], ctrl_q};
        end
    end

    // One wait cycle: data is captured on the same edge that waitrequest drops
    always_ff @(posedge CLK) begin
        if (RESET) begin
            wait_q  <= 1'b1;
            rdata_q <= '0;
        end else if (CE) begin
            if ((AVS_READ || AVS_WRITE) && wait_q) begin
                wait_q  <= 1'b0;
                rdata_q <= rd_d;
            end else begin
                wait_q <= 1'b1;
            end
        end
    end

    // ************************************************
    // Interrupt and open-drain outputs
    // ************************************************
    // Buffer low drives low; alarms add to output a when enabled
    always_ff @(posedge CLK) begin
        if (RESET) begin
            irq_q      <= 1'b0;
            oda_oe_n_q <= 1'b1;
            odb_oe_n_q <= 1'b1;
            od_low_q   <= 1'b0;
        end else if (CE) begin
            irq_q      <= |(flags_q & mask_q);
            oda_oe_n_q <= pin_s2_q[PIN_BUF_A] && !(ctrl_q[CTRL_ALARM_OUT]
                          && |{flags_q.hi, flags_q.lo});
            odb_oe_n_q <= pin_s2_q[PIN_BUF_B];
            od_low_q   <= 1'b0;
        end
    end

    assign AVS_READDATA          = rdata_q;
    assign AVS_WAITREQUEST       = wait_q;
    assign IRQ                   = irq_q;
    assign CONV_START            = start_q;
    assign CONV_CHANNEL          = ch_q;
    assign OPEN_DRAIN_OUT_A_O    = od_low_q;
    assign OPEN_DRAIN_OUT_A_OE_N = oda_oe_n_q;
    assign OPEN_DRAIN_OUT_B_O    = od_low_q;
    assign OPEN_DRAIN_OUT_B_OE_N = odb_oe_n_q;

    // ************************************************
    // Assertions
    // ************************************************
    AST_STORE: assert property (@(posedge CLK) disable iff (RESET)
        (CE && smp.valid) |=> res_q[$past(ch_q)] == $past(code_lj))
        else $error("result not stored");

    AST_DONE: assert property (@(posedge CLK) disable iff (RESET)
        (CE && smp.valid) |=> |(flags_q.done & $past(ch_oh)))
        else $error("done bit not set");

    AST_ALARM_HI: assert property (@(posedge CLK) disable iff (RESET)
        (CE && smp.valid && |(hi_hit & ch_oh))
        |=> |(flags_q.hi & $past(ch_oh)))
        else $error("high alarm missed");

    AST_ALARM_LO: assert property (@(posedge CLK) disable iff (RESET)
        (CE && smp.valid && |(lo_hit & ch_oh))
        |=> |(flags_q.lo & $past(ch_oh)))
        else $error("low alarm missed");

    AST_LOW_NIBBLE: assert property (@(posedge CLK) disable iff (RESET)
        (AVS_READ && !AVS_WAITREQUEST && in_res) |-> AVS_READDATA[3:0] == 4'h0)
        else $error("low bits of result not zero");

    AST_ORDER: assert property (@(posedge CLK) disable iff (RESET)
        (CE && slot_end) |=> ch_q == (($past(ch_q) == CH_LAST)
                                      ? CH_TEMP : $past(ch_q) + 3'h1))
        else $error("channel order broken");

    AST_IRQ: assert property (@(posedge CLK) disable iff (RESET)
        (CE && |(flags_q & mask_q)) |=> IRQ)
        else $error("interrupt not raised");

    AST_OUT_A: assert property (@(posedge CLK) disable iff (RESET)
        (CE && ctrl_q[CTRL_ALARM_OUT] && |{flags_q.hi, flags_q.lo})
        |=> !OPEN_DRAIN_OUT_A_OE_N)
        else $error("alarm did not drive output a");

    AST_BUF_B: assert property (@(posedge CLK) disable iff (RESET)
        CE |=> OPEN_DRAIN_OUT_B_OE_N == $past(pin_s2_q[PIN_BUF_B]))
        else $error("buffer b does not follow input");

    AST_WP_LOW: assert property (@(posedge CLK) disable iff (RESET)
        (wr_ok && !pin_s2_q[PIN_WP] && AVS_ADDRESS == OFS_MASK
         && AVS_BYTEENABLE == 4'hf)
        |=> mask_q == $past(AVS_WRITEDATA[3*NCH-1:0]))
        else $error("write refused with protect pin low");

endmodule

// file: tb/fcma_adc_model.sv
// Behavioural serial converter that answers every conversion start.
// Assumes CONV_START and CONV_CHANNEL come from the monitor on the same clock.
`timescale 1ns/1ps
module fcma_adc_model import fcma_pkg::*; (
    input  logic                 clk,
    input  logic                 reset,
    input  logic                 conv_start,
    input  logic [2:0]           conv_channel,
    input  logic [NCH-1:0][15:0] codes,
    output logic                 sclk,
    output logic                 sdata
);
    logic [15:0] word_q;
    logic [4:0]  bits_q;
    logic [2:0]  phase_q;

    // Eight cycles a bit make a 200 ns link clock; it stands low between words
    always @(posedge clk) begin
        if (reset || conv_start) begin
            word_q  <= codes[conv_channel];
            bits_q  <= reset ? 5'h00 : 5'h10;
            phase_q <= 3'h0;
            sclk    <= 1'b0;
            sdata   <= 1'b0;
        end else if (bits_q != 5'h00) begin
            phase_q <= phase_q + 3'h1;
            if (phase_q == 3'h0) begin
                sdata <= word_q[15];           // MSB first, set well before the rise
            end
            if (phase_q == 3'h3) begin
                sclk <= 1'b1;
            end
            if (phase_q == 3'h7) begin
                sclk   <= 1'b0;
                word_q <= {word_q[14:0], 1'b0};
                bits_q <= bits_q - 5'h01;
            end
        end else begin
            sdata <= ~sdata;                   // Released line has no pull: never trust it
        end
    end
endmodule

// file: tb/five_channel_monitor_alarm_tb_top.sv
// Self-checking bench for the five-channel monitor over its register bus.
// Assumes the converter model answers each slot and that CE stays high.
`timescale 1ns/1ps
module five_channel_monitor_alarm_tb_top import fcma_pkg::*;;
    localparam int SLOT  = 200;
    localparam int FRAME = SLOT * NCH;
    logic                 clk    = 1'b0;
    logic                 reset  = 1'b1;
    logic [7:0]           addr   = 8'h00;
    logic                 rd     = 1'b0;
    logic                 wr     = 1'b0;
    logic [31:0]          wdata  = 32'h0;
    logic                 buf_a  = 1'b1;
    logic                 buf_b  = 1'b1;
    logic                 wp_pin = 1'b1;
    logic [31:0]          rdata, d;
    logic                 waitreq, irq, cstart, sclk, sdata;
    logic                 oe_n_a, oe_n_b, o_a, o_b;
    logic [2:0]           cchan;
    logic [2:0]           exp_ch = 3'h0;
    int                   gap = 0;
    int                   num_errors = 0;
    int                   compares = 0;
    logic [NCH-1:0][15:0] codes = {16'h0007, 16'hffff, 16'h1238, 16'h9005, 16'h8013};

    // Pulled-up open-drain pins: low only while an output enable is low
    wire pin_a = oe_n_a ? 1'b1 : o_a;
    wire pin_b = oe_n_b ? 1'b1 : o_b;

    always #12.5 clk = ~clk;

    fcma_top #(.SLOT_CYCLES(SLOT)) u_dut (
        .CLK(clk), .RESET(reset), .CE(1'b1),
        .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .IRQ(irq),
        .CONV_START(cstart), .CONV_CHANNEL(cchan),
        .ADC_SCLK(sclk), .ADC_SDATA(sdata),
        .BUFFER_IN_A(buf_a), .BUFFER_IN_B(buf_b), .WRITE_PROTECT_PIN(wp_pin),
        .OPEN_DRAIN_OUT_A_I(pin_a), .OPEN_DRAIN_OUT_A_O(o_a), .OPEN_DRAIN_OUT_A_OE_N(oe_n_a),
        .OPEN_DRAIN_OUT_B_I(pin_b), .OPEN_DRAIN_OUT_B_O(o_b), .OPEN_DRAIN_OUT_B_OE_N(oe_n_b)
    );

    fcma_adc_model u_adc (
        .clk(clk), .reset(reset), .conv_start(cstart), .conv_channel(cchan),
        .codes(codes), .sclk(sclk), .sdata(sdata)
    );

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One transfer, held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        addr  <= a;
        wdata <= v;
        wr    <= w;
        rd    <= ~w;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 64);
        d = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (waitreq !== 1'b0) begin
            num_errors++;
            conclude();
        end
        @(posedge clk);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(d, exp);
    endtask

    // Margin covers the last word landing after its slot starts
    task automatic frames(input int n);
        repeat (n * FRAME + 50) @(posedge clk);
    endtask

    // Slot starts walk the channels in fixed rotation, one slot apart
    always @(posedge clk) begin
        if (reset) begin
            exp_ch <= 3'h0;
            gap    <= 0;
        end else if (cstart === 1'b1) begin
            chk({29'h0, cchan}, {29'h0, exp_ch});
            if (gap > 8) chk(32'(gap), 32'(SLOT));
            exp_ch <= (exp_ch == CH_LAST) ? 3'h0 : exp_ch + 3'h1;
            gap    <= 1;
        end else begin
            gap <= gap + 1;
        end
    end

    // A hang ends the run as a mismatch
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        conclude();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rdchk(OFS_STATUS, 32'h0);
        rdchk(OFS_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        frames(1);
        // Host view: only the twelve upper bits carry the measurement
        for (int i = 0; i < NCH; i++) begin
            rdchk(8'(4 * i), {16'h0, codes[i] & 16'hfff0});
            chk({20'h0, d[15:4]}, {20'h0, codes[i][15:4]});
        end
        rdchk(OFS_STATUS, 32'h1f);
        // Temperature high limit would trip if compared unsigned
        bus(1'b1, OFS_LIMIT, 32'h1000);
        bus(1'b1, OFS_LIMIT + 8'h04, 32'h0);
        bus(1'b1, OFS_LIMIT + 8'h08, 32'h8000);
        bus(1'b1, OFS_STATUS, 32'h7fff);
        frames(1);
        rdchk(OFS_STATUS, 32'h045f);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, OFS_MASK, 32'h400);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, OFS_LIMIT + 8'h04, 32'h8000);
        bus(1'b1, OFS_STATUS, 32'h7fff);
        frames(1);
        rdchk(OFS_STATUS, 32'h005f);
        chk({31'h0, irq}, 32'h0);
        // Every input pair reaches the open-drain enables
        for (int v = 0; v < 4; v++) begin
            buf_a <= v[0];
            buf_b <= v[1];
            repeat (6) @(posedge clk);
            chk({30'h0, oe_n_b, oe_n_a}, 32'(v));
            chk({30'h0, o_b, o_a}, 32'h0);
        end
        bus(1'b1, OFS_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        chk({31'h0, oe_n_a}, 32'h0);
        // Pin a reads back low through its synchroniser while driven
        rdchk(OFS_CTRL, 32'h19);
        bus(1'b1, OFS_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        chk({31'h0, oe_n_a}, 32'h1);
        // Pin high plus protect bit blocks writes; pin low lifts it
        bus(1'b1, OFS_CTRL, 32'h2);
        bus(1'b0, OFS_CTRL, 32'h0);
        chk(d & 32'h13, 32'h12);
        bus(1'b1, OFS_MASK, 32'h1);
        rdchk(OFS_MASK, 32'h400);
        bus(1'b1, OFS_LIMIT, 32'h0);
        rdchk(OFS_LIMIT, 32'h1000);
        wp_pin <= 1'b0;
        repeat (4) @(posedge clk);
        bus(1'b1, OFS_MASK, 32'h1);
        rdchk(OFS_MASK, 32'h1);
        bus(1'b1, 8'h4c, 32'hffff);
        rdchk(8'h4c, 32'h0);
        conclude();
    end
endmodule
